// >>> core/cpu_exec_consts.vh
// Purpose: constants for the move, load and jump execution unit
// Assumes: included by bare name from every design file
// Notes: file register 0 is A, file register 1 is B
`ifndef CPU_EXEC_CONSTS_VH
`define CPU_EXEC_CONSTS_VH
// Flag word bit positions, reset values, register numbers and peripheral page
`define FW_C 7
`define FW_N 6
`define FW_Z 5
`define FW_V 4
`define FW_IRQ2 3
`define FW_IRQ1 2
`define FW_RST 8'h00
`define SP_RST 8'h01
`define PC_RST 16'h0000
`define REG_A 8'h00
`define REG_B 8'h01
`define PERIPH_PAGE 8'h10
// Opcodes
`define OP_J_NEG 8'h01
`define OP_J_EQ 8'h02
`define OP_J_CS 8'h03
`define OP_J_PZ 8'h05
`define OP_J_NE 8'h06
`define OP_J_CC 8'h07
`define OP_J_OV 8'h08
`define OP_J_HS 8'h0B
`define OP_J_NOV 8'h0C
`define OP_J_LO 8'h0F
`define OP_SPLD 8'hFD
`define OP_FWLD 8'hF0
`define OP_BT_A_B 8'hC0
`define OP_BT_A_R 8'hD0
`define OP_BT_B_A 8'h62
`define OP_BT_B_R 8'hD1
`define OP_BT_R_A 8'h12
`define OP_BT_R_B 8'h32
`define OP_BT_R_R 8'h42
`define OP_BT_I_A 8'h22
`define OP_BT_I_B 8'h52
`define OP_BT_I_R 8'h72
`define OP_BT_A_P 8'h21
`define OP_BT_B_P 8'h51
`define OP_BT_R_P 8'h71
`define OP_BT_P_A 8'h80
`define OP_BT_P_B 8'h91
`define OP_BT_P_R 8'hA2
`define OP_BT_I_P 8'hF7
`define OP_BT_X_A 8'h8A
`define OP_BT_A_X 8'h8B
`define OP_MW_I 8'h88
`define OP_MW_R 8'h98
`define OP_MW_PFX 8'hF4
`define OP_MW_O 8'hE8
`define OP_MW_B 8'hA8
// Cycle counts per instruction
`define CY_JMP 5'd7
`define CY_SPLD 5'd7
`define CY_FWLD 5'd6
`define CY_BT_AB 5'd9
`define CY_BT_BA 5'd8
`define CY_BT_XR 5'd7
`define CY_BT_RR 5'd9
`define CY_BT_IA 5'd6
`define CY_BT_IR 5'd8
`define CY_BT_P2 5'd8
`define CY_BT_P3 5'd10
`define CY_BT_EXT 5'd10
`define CY_MW_I 5'd13
`define CY_MW_R 5'd12
`define CY_MW_O 5'd20
`define CY_MW_B 5'd15
`define CY_BAD 5'd6
// Lengths and byte positions
`define L1 3'd1
`define L2 3'd2
`define L3 3'd3
`define L4 3'd4
`define L5 3'd5
`define BY0 3'd0
`define BY1 3'd1
`define BY2 3'd2
`define BY3 3'd3
`define BY4 3'd4
// Operand kinds
`define K_A 3'd0
`define K_B 3'd1
`define K_R 3'd2
`define K_I 3'd3
`define K_P 3'd4
`define K_X 3'd5
// Instruction classes
`define C_JMP 4'd0
`define C_SPLD 4'd1
`define C_FWLD 4'd2
`define C_BT 4'd3
`define C_MWI 4'd4
`define C_MWR 4'd5
`define C_MWO 4'd6
`define C_MWB 4'd7
`define C_BAD 4'd8
// Host port register addresses and control register bit positions
`define HR_CTRL 3'd0
`define HR_FW 3'd1
`define HR_PCL 3'd2
`define HR_PCH 3'd3
`define HR_SP 3'd4
`define CTRL_RUN 0
`define CTRL_BUSY 1
`endif

// >>> core/op_decode.v
// Purpose: opcode to length, cycle count, class and operand layout
// Assumes: op2 is only trusted once the second byte is fetched
// Notes: purely combinational
`timescale 1ns/1ps
`include "cpu_exec_consts.vh"
module op_decode
(
    // Opcode bytes
    input  wire [7:0] op,
    input  wire [7:0] op2,
    // Decoded attributes
    output wire [2:0] len,
    output wire [4:0] cyc,
    output wire [3:0] cls,
    output wire [2:0] src_k,
    output wire [2:0] dst_k,
    output wire [2:0] src_pos,
    output wire [2:0] dst_pos
);
    reg [23:0] d;

    function [23:0] pk;
        input [2:0] l;
        input [4:0] c;
        input [3:0] k;
        input [2:0] s;
        input [2:0] t;
        input [2:0] sp;
        input [2:0] dp;
        begin
            pk = {l, c, k, s, t, sp, dp};
        end
    endfunction

    always @*
    begin
        case (op)
            `OP_J_NEG, `OP_J_EQ, `OP_J_CS, `OP_J_PZ, `OP_J_NE, `OP_J_CC,
            `OP_J_OV, `OP_J_HS, `OP_J_NOV, `OP_J_LO:
                d = pk(`L2, `CY_JMP, `C_JMP, `K_I, `K_I, `BY1, `BY0);
            `OP_SPLD: d = pk(`L1, `CY_SPLD, `C_SPLD, `K_B, `K_B, `BY0, `BY0);
            `OP_FWLD: d = pk(`L2, `CY_FWLD, `C_FWLD, `K_I, `K_I, `BY1, `BY0);
            // Byte transfer forms other than the file-peripheral and extended ones
            `OP_BT_A_B: d = pk(`L1, `CY_BT_AB, `C_BT, `K_A, `K_B, `BY0, `BY0);
            `OP_BT_B_A: d = pk(`L1, `CY_BT_BA, `C_BT, `K_B, `K_A, `BY0, `BY0);
            `OP_BT_A_R: d = pk(`L2, `CY_BT_XR, `C_BT, `K_A, `K_R, `BY0, `BY1);
            `OP_BT_B_R: d = pk(`L2, `CY_BT_XR, `C_BT, `K_B, `K_R, `BY0, `BY1);
            `OP_BT_R_A: d = pk(`L2, `CY_BT_XR, `C_BT, `K_R, `K_A, `BY1, `BY0);
            `OP_BT_R_B: d = pk(`L2, `CY_BT_XR, `C_BT, `K_R, `K_B, `BY1, `BY0);
            `OP_BT_R_R: d = pk(`L3, `CY_BT_RR, `C_BT, `K_R, `K_R, `BY1, `BY2);
            `OP_BT_I_A: d = pk(`L2, `CY_BT_IA, `C_BT, `K_I, `K_A, `BY1, `BY0);
            `OP_BT_I_B: d = pk(`L2, `CY_BT_IA, `C_BT, `K_I, `K_B, `BY1, `BY0);
            `OP_BT_I_R: d = pk(`L3, `CY_BT_IR, `C_BT, `K_I, `K_R, `BY1, `BY2);
            `OP_BT_I_P: d = pk(`L3, `CY_BT_P3, `C_BT, `K_I, `K_P, `BY1, `BY2);
            `OP_BT_A_P: d = pk(`L2, `CY_BT_P2, `C_BT, `K_A, `K_P, `BY0, `BY1);
            `OP_BT_B_P: d = pk(`L2, `CY_BT_P2, `C_BT, `K_B, `K_P, `BY0, `BY1);
            `OP_BT_P_A: d = pk(`L2, `CY_BT_P2, `C_BT, `K_P, `K_A, `BY1, `BY0);
            `OP_BT_P_B: d = pk(`L2, `CY_BT_P2, `C_BT, `K_P, `K_B, `BY1, `BY0);
            // Peripheral byte sits first for a file source, second for a file target
            `OP_BT_R_P: d = pk(`L3, `CY_BT_P3, `C_BT, `K_R, `K_P, `BY2, `BY1);
            `OP_BT_P_R: d = pk(`L3, `CY_BT_P3, `C_BT, `K_P, `K_R, `BY2, `BY1);
            // Extended forms only ever pair with A
            `OP_BT_X_A: d = pk(`L3, `CY_BT_EXT, `C_BT, `K_X, `K_A, `BY1, `BY0);
            `OP_BT_A_X: d = pk(`L3, `CY_BT_EXT, `C_BT, `K_A, `K_X, `BY0, `BY1);
            `OP_MW_I: d = pk(`L4, `CY_MW_I, `C_MWI, `K_I, `K_R, `BY1, `BY3);
            `OP_MW_R: d = pk(`L3, `CY_MW_R, `C_MWR, `K_R, `K_R, `BY1, `BY2);
            `OP_MW_PFX: d = pk(`L5, `CY_MW_O, (op2 == `OP_MW_O) ? `C_MWO : `C_BAD,
                               `K_R, `K_R, `BY2, `BY4);
            `OP_MW_B: d = pk(`L4, `CY_MW_B, `C_MWB, `K_I, `K_R, `BY1, `BY3);
            default: d = pk(`L1, `CY_BAD, `C_BAD, `K_A, `K_A, `BY0, `BY0);
        endcase
    end

    assign {len, cyc, cls, src_k, dst_k, src_pos, dst_pos} = d;
endmodule // op_decode

// >>> core/cpu_move_load_jump_exec.v
// Purpose: executes jumps, stack/flag loads, byte and word transfers
// Assumes: program memory returns data one cycle after its address
// Notes: every instruction retires exactly at its documented cycle count
`timescale 1ns/1ps
`include "cpu_exec_consts.vh"
module cpu_move_load_jump_exec
(
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Program memory
    output wire [15:0] pm_addr,
    input  wire [7:0]  pm_rdata,
    // Peripheral and extended space
    output wire [15:0] mem_addr,
    output wire [7:0]  mem_wdata,
    output wire        mem_we,
    output wire        mem_re,
    input  wire [7:0]  mem_rdata,
    // Host register port
    input  wire [2:0]  hp_addr,
    input  wire [7:0]  hp_wdata,
    input  wire        hp_wr,
    input  wire        hp_rd,
    output wire [7:0]  hp_rdata,
    // Status
    output wire [7:0]  stack_pointer,
    output wire        irq_enable_level_one,
    output wire        irq_enable_level_two,
    output wire        retire
);
    localparam S_IDLE  = 7'b0000001;
    localparam S_FETCH = 7'b0000010;
    localparam S_CAPT  = 7'b0000100;
    localparam S_EXEC  = 7'b0001000;
    localparam S_MEMA  = 7'b0010000;
    localparam S_MEMD  = 7'b0100000;
    localparam S_PAD   = 7'b1000000;

    // File registers, A and B included
    reg  [7:0]  rf [0:255];
    // Instruction bytes; sized up so pos+1 never leaves the array
    reg  [7:0]  ib_ff [0:7];
    reg  [6:0]  state_ff;
    reg  [2:0]  idx_ff;
    reg  [4:0]  cyc_ff;
    reg         run_ff;
    reg  [15:0] pc_ff;
    reg  [7:0]  sp_ff;
    reg  [7:0]  fw_ff;
    reg  [15:0] pm_addr_ff;
    reg  [15:0] mem_addr_ff;
    reg  [7:0]  mem_wdata_ff;
    reg         mem_we_ff;
    reg         mem_re_ff;
    reg  [7:0]  md_ff;
    reg  [7:0]  hp_rdata_ff;
    reg         retire_ff;

    wire [7:0]  dec_op;
    wire [2:0]  dec_len;
    wire [4:0]  dec_cyc;
    wire [3:0]  dec_cls;
    wire [2:0]  src_k;
    wire [2:0]  dst_k;
    wire [2:0]  src_pos;
    wire [2:0]  dst_pos;
    wire [7:0]  s0;
    wire [7:0]  s1;
    wire [7:0]  d0;
    wire [7:0]  d1;
    wire        commit;
    wire        taken;
    wire [15:0] pc_next;
    wire [15:0] src_ptr;
    wire [15:0] dst_ptr;
    wire [7:0]  wd_lo;
    wire [7:0]  wd_hi;
    reg  [7:0]  mv_val;
    reg  [15:0] word_val;
    reg  [7:0]  hp_val;

    function [15:0] sext;
        input [7:0] v;
        begin
            sext = {{8{v[7]}}, v};
        end
    endfunction

    function [7:0] prev;
        input [7:0] r;
        begin
            prev = r - 8'h01;
        end
    endfunction

    // Carry and overflow cleared, sign and zero taken from the byte given
    function [7:0] nz_flags;
        input [7:0] fw;
        input [7:0] v;
        begin
            nz_flags = fw;
            nz_flags[`FW_C] = 1'b0;
            nz_flags[`FW_V] = 1'b0;
            nz_flags[`FW_N] = v[7];
            nz_flags[`FW_Z] = (v == 8'h00);
        end
    endfunction

    function [15:0] ptr;
        input [2:0] k;
        input [7:0] b0;
        input [7:0] b1;
        begin
            ptr = (k == `K_P) ? {`PERIPH_PAGE, b0} : {b0, b1};
        end
    endfunction

    // Lower and higher-or-same read carry: set means no borrow
    function jump_taken;
        input [7:0] op;
        input [7:0] fw;
        begin
            case (op)
                `OP_J_NEG: jump_taken = fw[`FW_N];
                `OP_J_PZ:  jump_taken = ~fw[`FW_N];
                `OP_J_EQ:  jump_taken = fw[`FW_Z];
                `OP_J_NE:  jump_taken = ~fw[`FW_Z];
                `OP_J_CS:  jump_taken = fw[`FW_C];
                `OP_J_CC:  jump_taken = ~fw[`FW_C];
                `OP_J_OV:  jump_taken = fw[`FW_V];
                `OP_J_NOV: jump_taken = ~fw[`FW_V];
                `OP_J_HS:  jump_taken = fw[`FW_C];
                `OP_J_LO:  jump_taken = ~fw[`FW_C];
                default: jump_taken = 1'b0;
            endcase
        end
    endfunction

    // First byte is decoded straight off the memory bus to learn the length
    assign dec_op = (state_ff == S_CAPT && idx_ff == `BY0) ? pm_rdata : ib_ff[0];

    op_decode u_dec
    (
        .op      (dec_op),
        .op2     (ib_ff[1]),
        .len     (dec_len),
        .cyc     (dec_cyc),
        .cls     (dec_cls),
        .src_k   (src_k),
        .dst_k   (dst_k),
        .src_pos (src_pos),
        .dst_pos (dst_pos)
    );

    assign s0 = ib_ff[src_pos];
    assign s1 = ib_ff[src_pos + `BY1];
    assign d0 = ib_ff[dst_pos];
    assign d1 = ib_ff[dst_pos + `BY1];
    assign src_ptr = ptr(src_k, s0, s1);
    assign dst_ptr = ptr(dst_k, d0, d1);
    assign commit = (state_ff == S_PAD) && (cyc_ff >= dec_cyc);
    assign taken = jump_taken(ib_ff[0], fw_ff);
    // Own address plus offset, not the address after the jump
    assign pc_next = (dec_cls == `C_JMP && taken) ? pc_ff + sext(s0)
                                                  : pc_ff + {13'h0000, dec_len};
    // Low byte of the pair sits at the named register
    assign wd_lo = word_val[7:0];
    assign wd_hi = word_val[15:8];

    always @*
    begin
        case (src_k)
            `K_A: mv_val = rf[`REG_A];
            `K_B: mv_val = rf[`REG_B];
            `K_R: mv_val = rf[s0];
            `K_I: mv_val = s0;
            default: mv_val = md_ff;
        endcase
    end

    always @*
    begin
        case (dec_cls)
            `C_MWI: word_val = {s0, s1};
            `C_MWR: word_val = {rf[prev(s0)], rf[s0]};
            `C_MWO: word_val = {rf[prev(s1)], rf[s1]} + sext(s0);
            `C_MWB: word_val = {s0, s1} + {8'h00, rf[`REG_B]};
            default: word_val = 16'h0000;
        endcase
    end

    always @*
    begin
        case (hp_addr)
            `HR_CTRL: hp_val = {6'h00, state_ff != S_IDLE, run_ff};
            `HR_FW:   hp_val = fw_ff;
            `HR_PCL:  hp_val = pc_ff[7:0];
            `HR_PCH:  hp_val = pc_ff[15:8];
            `HR_SP:   hp_val = sp_ff;
            default:  hp_val = 8'h00;
        endcase
    end

    // Host port
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            run_ff      <= 1'b0;
            hp_rdata_ff <= 8'h00;
        end
        else
        begin
            hp_rdata_ff <= hp_rd ? hp_val : 8'h00;
            if (hp_wr && hp_addr == `HR_CTRL)
            begin
                run_ff <= hp_wdata[`CTRL_RUN];
            end
        end
    end

    // Register file has no reset; software initialises what it uses
    always @(posedge mclk)
    begin
        if (rst_n && commit)
        begin
            case (dec_cls)
                `C_BT:
                begin
                    if (dst_k == `K_A)
                    begin
                        rf[`REG_A] <= mv_val;
                    end
                    else if (dst_k == `K_B)
                    begin
                        rf[`REG_B] <= mv_val;
                    end
                    else if (dst_k == `K_R)
                    begin
                        rf[d0] <= mv_val;
                    end
                end
                `C_MWI, `C_MWR, `C_MWO, `C_MWB:
                begin
                    // A zero target wraps the high byte to the top register
                    rf[d0]       <= wd_lo;
                    rf[prev(d0)] <= wd_hi;
                end
                default:
                begin
                end
            endcase
        end
    end

    // Sequencer and architectural state
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff     <= S_IDLE;
            idx_ff       <= `BY0;
            cyc_ff       <= 5'd0;
            pc_ff        <= `PC_RST;
            sp_ff        <= `SP_RST;
            fw_ff        <= `FW_RST;
            pm_addr_ff   <= `PC_RST;
            mem_addr_ff  <= 16'h0000;
            mem_wdata_ff <= 8'h00;
            mem_we_ff    <= 1'b0;
            mem_re_ff    <= 1'b0;
            md_ff        <= 8'h00;
            retire_ff    <= 1'b0;
            ib_ff[0]     <= 8'h00;
            ib_ff[1]     <= 8'h00;
            ib_ff[2]     <= 8'h00;
            ib_ff[3]     <= 8'h00;
            ib_ff[4]     <= 8'h00;
            ib_ff[5]     <= 8'h00;
            ib_ff[6]     <= 8'h00;
            ib_ff[7]     <= 8'h00;
        end
        else
        begin
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            retire_ff <= 1'b0;
            cyc_ff    <= cyc_ff + 5'd1;
            case (state_ff)
                S_IDLE:
                begin
                    cyc_ff <= 5'd0;
                    if (hp_wr && hp_addr == `HR_PCL)
                    begin
                        pc_ff[7:0] <= hp_wdata;
                    end
                    if (hp_wr && hp_addr == `HR_PCH)
                    begin
                        pc_ff[15:8] <= hp_wdata;
                    end
                    if (run_ff)
                    begin
                        pm_addr_ff <= pc_ff;
                        idx_ff     <= `BY0;
                        cyc_ff     <= 5'd1;
                        state_ff   <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    state_ff <= S_CAPT;
                end
                S_CAPT:
                begin
                    ib_ff[idx_ff] <= pm_rdata;
                    if (idx_ff + `BY1 < dec_len)
                    begin
                        idx_ff     <= idx_ff + `BY1;
                        pm_addr_ff <= pm_addr_ff + 16'h0001;
                        state_ff   <= S_FETCH;
                    end
                    else
                    begin
                        state_ff <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    // Only byte transfers reach the outside space
                    if (dec_cls == `C_BT && (src_k == `K_P || src_k == `K_X))
                    begin
                        mem_addr_ff <= src_ptr;
                        mem_re_ff   <= 1'b1;
                        state_ff    <= S_MEMA;
                    end
                    else
                    begin
                        state_ff <= S_PAD;
                    end
                end
                S_MEMA:
                begin
                    state_ff <= S_MEMD;
                end
                S_MEMD:
                begin
                    md_ff    <= mem_rdata;
                    state_ff <= S_PAD;
                end
                S_PAD:
                begin
                    if (commit)
                    begin
                        retire_ff <= 1'b1;
                        pc_ff     <= pc_next;
                        case (dec_cls)
                            `C_SPLD: sp_ff <= rf[`REG_B];
                            // Enable and disable ops arrive here as fixed immediates
                            `C_FWLD: fw_ff <= s0;
                            `C_BT:
                            begin
                                fw_ff <= nz_flags(fw_ff, mv_val);
                                if (dst_k == `K_P || dst_k == `K_X)
                                begin
                                    mem_addr_ff  <= dst_ptr;
                                    mem_wdata_ff <= mv_val;
                                    mem_we_ff    <= 1'b1;
                                end
                            end
                            `C_MWI, `C_MWR, `C_MWO, `C_MWB:
                                fw_ff <= nz_flags(fw_ff, wd_hi);
                            default:
                            begin
                            end
                        endcase
                        if (run_ff)
                        begin
                            pm_addr_ff <= pc_next;
                            idx_ff     <= `BY0;
                            cyc_ff     <= 5'd1;
                            state_ff   <= S_FETCH;
                        end
                        else
                        begin
                            state_ff <= S_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    assign pm_addr              = pm_addr_ff;
    assign mem_addr             = mem_addr_ff;
    assign mem_wdata            = mem_wdata_ff;
    assign mem_we               = mem_we_ff;
    assign mem_re               = mem_re_ff;
    assign hp_rdata             = hp_rdata_ff;
    assign stack_pointer        = sp_ff;
    assign irq_enable_level_one = fw_ff[`FW_IRQ1];
    assign irq_enable_level_two = fw_ff[`FW_IRQ2];
    assign retire               = retire_ff;
endmodule // cpu_move_load_jump_exec

// >>> testbench/exec_properties.sv
// Purpose: timing checks on the move, load and jump unit
// Assumes: one clock, synchronous active-low reset
// Notes: opcode shows on pm_rdata one cycle after retire
`timescale 1ns/1ps
module exec_properties
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Observed ports
    input wire logic [7:0] pm_rdata,
    input wire logic [7:0] stack_pointer,
    input wire logic       irq_enable_level_one,
    input wire logic       irq_enable_level_two,
    input wire logic       mem_we,
    input wire logic       mem_re,
    input wire logic       retire
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Retire marks cycle 1 of the next instruction
    sequence s_op(logic [7:0] o);
        retire ##1 pm_rdata == o;
    endsequence
    a_spld_cycles: assert property (s_op(8'hFD) |-> !retire [*6] ##1 retire)
        else $error("stack pointer load length wrong");
    a_fwld_cycles: assert property (s_op(8'hF0) |-> !retire [*5] ##1 retire)
        else $error("flag word load length wrong");
    a_mwi_cycles: assert property (s_op(8'h88) |-> ##12 retire)
        else $error("immediate word move length wrong");
    a_mwr_cycles: assert property (s_op(8'h98) |-> ##11 retire)
        else $error("pair word move length wrong");
    a_mwo_cycles: assert property (s_op(8'hF4) |-> ##19 retire)
        else $error("offset word move length wrong");
    a_mwb_cycles: assert property (s_op(8'hA8) |-> ##14 retire)
        else $error("indexed word move length wrong");
    a_sp_commit: assert property (!$stable(stack_pointer) |-> retire)
        else $error("stack pointer moved off commit");
    a_ie_commit: assert property
        (!$stable({irq_enable_level_one, irq_enable_level_two}) |-> retire)
        else $error("interrupt enables moved off commit");
    a_we_retire: assert property (mem_we |-> retire)
        else $error("write outside retire cycle");
    a_retire_gap: assert property (retire |=> !retire [*4])
        else $error("retire pulses too close");
    a_read_once: assert property (mem_re |=> !mem_re)
        else $error("read pulse too long");
endmodule // exec_properties

bind cpu_move_load_jump_exec exec_properties u_props
(
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .pm_rdata             (pm_rdata),
    .stack_pointer        (stack_pointer),
    .irq_enable_level_one (irq_enable_level_one),
    .irq_enable_level_two (irq_enable_level_two),
    .mem_we               (mem_we),
    .mem_re               (mem_re),
    .retire               (retire)
);

// >>> testbench/tb_cpu_move_load_jump_exec.sv
// Purpose: self-checking bench for the move, load and jump unit
// Assumes: program and peripheral memories modelled here
// Notes: unknown opcode FF pads programs as a no-effect filler
`timescale 1ns/1ps
module tb_cpu_move_load_jump_exec;
    logic         mclk = 1'b0;
    logic         rst_n = 1'b0;
    logic [15:0]  pm_addr;
    logic [15:0]  mem_addr;
    logic [7:0]   pm_rdata = 8'hFF;
    logic [7:0]   mem_rdata = 8'h00;
    logic [7:0]   mem_wdata;
    logic         mem_we;
    logic         mem_re;
    logic [2:0]   hp_addr = 3'h0;
    logic [7:0]   hp_wdata = 8'h00;
    logic         hp_wr = 1'b0;
    logic         hp_rd = 1'b0;
    logic [7:0]   hp_rdata;
    logic [7:0]   stack_pointer;
    logic         irq_enable_level_one;
    logic         irq_enable_level_two;
    logic         retire;
    logic [7:0]   rd;
    logic [7:0]   pm [0:255];
    logic [7:0]   per [0:255];
    int           n_errors = 0;
    int           samples_checked = 0;

    cpu_move_load_jump_exec uut
    (
        .mclk(mclk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_re(mem_re), .mem_rdata(mem_rdata), .hp_addr(hp_addr),
        .hp_wdata(hp_wdata), .hp_wr(hp_wr), .hp_rd(hp_rd), .hp_rdata(hp_rdata),
        .stack_pointer(stack_pointer), .irq_enable_level_one(irq_enable_level_one),
        .irq_enable_level_two(irq_enable_level_two), .retire(retire)
    );

    always #25 mclk = ~mclk;

    // Undriven read data toggles so stale bytes never match
    always @(posedge mclk)
    begin
        pm_rdata <= pm[pm_addr[7:0]];
        mem_rdata <= mem_re ? per[mem_addr[7:0]] : ~mem_rdata;
        if (mem_we)
            per[mem_addr[7:0]] <= mem_wdata;
    end

    task close_out;
        $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task hwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        hp_wr <= 1'b1;
        hp_addr <= a;
        hp_wdata <= d;
        @(posedge mclk);
        hp_wr <= 1'b0;
    endtask

    task hrd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        hp_rd <= 1'b1;
        hp_addr <= a;
        @(posedge mclk);
        hp_rd <= 1'b0;
        #1 d = hp_rdata;
    endtask

    task wait_ret;
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            #1 k++;
        end while (retire !== 1'b1 && k < 40);
        if (k >= 40)
            n_errors++;
    endtask

    // Stopping lets one more instruction finish, so wait for it
    task run(input int n);
        int k;
        k = 0;
        do
        begin
            hrd(3'h0, rd);
            k++;
        end while (rd[1] !== 1'b0 && k < 9);
        if (rd[1] !== 1'b0)
            n_errors++;
        hwr(3'h2, 8'h00);
        hwr(3'h3, 8'h00);
        hwr(3'h0, 8'h01);
        repeat (n) wait_ret;
        hwr(3'h0, 8'h00);
        wait_ret;
    endtask

    task test_moves;
        logic [351:0] pg;
        pg = {176'h5280FDF08C88123403980305A8100007F4E8FE050971,
              176'h0102710207710306710409A2050471060522808B1007};
        for (int i = 0; i < 44; i++)
            pm[i] = pg[351 - 8 * i -: 8];
        run(15);
        chk(stack_pointer, 8'h80);
        chk({6'h00, irq_enable_level_two, irq_enable_level_one}, 8'h03);
        hrd(3'h1, rd);
        chk(rd, 8'h4C);
        chk(per[1], 8'h12);
        chk(per[2], 8'h80);
        chk(per[3], 8'h10);
        chk(per[4], 8'h32);
        chk(per[6], 8'h32);
        chk(per[7], 8'h80);
        hrd(3'h5, rd);
        chk(rd, 8'h00);
        $display("test_moves done");
    endtask

    // Each entry: opcode, tested flag mask, taken when that flag is set
    task test_jumps;
        logic [239:0] jt;
        logic [23:0]  e;
        jt = 240'h0140010220010380010540000620000780000810010B80010C10000F8000;
        for (int i = 0; i < 20; i++)
        begin
            e = jt[239 - 24 * (i / 2) -: 24];
            pm[0] = 8'hF0;
            pm[1] = (i % 2) ? ~e[15:8] : e[15:8];
            pm[2] = e[23:16];
            pm[3] = 8'hFE;
            run(2);
            hrd(3'h2, rd);
            chk(rd, (e[0] ^ (i % 2)) ? 8'h02 : 8'h05);
        end
        $display("test_jumps done");
    endtask

    // Equal jump then carry jump to one target; entry: second opcode, flags, final PC
    task test_pairs;
        logic [143:0] pt;
        logic [23:0]  e;
        pt = 144'h0F2009_0F0008_0F8006_0B2009_0B8008_0B0006;
        for (int i = 0; i < 6; i++)
        begin
            e = pt[143 - 24 * i -: 24];
            pm[0] = 8'hF0;
            pm[1] = e[15:8];
            pm[2] = 8'h02;
            pm[3] = 8'h06;
            pm[4] = e[23:16];
            pm[5] = 8'h04;
            pm[6] = 8'hFF;
            pm[8] = 8'hFF;
            pm[9] = 8'hFF;
            run(2);
            hrd(3'h2, rd);
            chk(rd, e[7:0]);
        end
        $display("test_pairs done");
    endtask

    initial
    begin
        #1000000;
        n_errors++;
        close_out;
    end

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            pm[i] = 8'hFF;
            per[i] = 8'h00;
        end
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        test_moves;
        test_jumps;
        test_pairs;
        close_out;
    end
endmodule // tb_cpu_move_load_jump_exec
